// [sdm_pkg.sv]
package sdm_pkg;

  // --------------------------------------------------------------
  // request byte fields
  // --------------------------------------------------------------
  localparam int REQ_MAGNET = 0;
  localparam int REQ_RESET = 7;

  // --------------------------------------------------------------
  // response byte fields
  // --------------------------------------------------------------
  localparam int RSP_OUT_ON = 0;
  localparam int RSP_ACT = 1;
  localparam int RSP_LOCKED = 2;
  localparam int RSP_SPARE = 3;
  localparam int RSP_INPUTS = 4;
  localparam int RSP_DOOR = 5;
  localparam int RSP_WARN = 6;
  localparam int RSP_ERR = 7;

  // --------------------------------------------------------------
  // diagnostic byte fields
  // --------------------------------------------------------------
  localparam int DG_OUT_A = 0;
  localparam int DG_OUT_B = 1;
  localparam int DG_CROSS = 2;
  localparam int DG_TEMP = 3;
  localparam int DG_ACT_BAD = 4;
  localparam int DG_INTERNAL = 5;
  localparam int DG_COMM = 6;
  localparam int DG_LOW_V = 7;
  localparam int DG_NWARN = 4;

  // --------------------------------------------------------------
  // pin vector positions
  // --------------------------------------------------------------
  localparam int P_IN_A = 0;
  localparam int P_IN_B = 1;
  localparam int P_ACT = 2;
  localparam int P_LOCKED = 3;
  localparam int P_DOOR = 4;
  localparam int P_FLT_A = 5;
  localparam int P_FLT_B = 6;
  localparam int P_CROSS = 7;
  localparam int P_TEMP = 8;
  localparam int P_ACT_BAD = 9;
  localparam int P_INTERNAL = 10;
  localparam int P_LOW_V = 11;
  localparam int NPIN = 12;

  // --------------------------------------------------------------
  // reset values and timing
  // --------------------------------------------------------------
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam int ESC_W = 40;
  localparam longint ESC_TIME_MIN = 30;
  localparam longint CLK_HZ = 50_000_000;
  localparam logic [ESC_W-1:0] ESC_CYCLES_DEF = ESC_W'(ESC_TIME_MIN * 60 * CLK_HZ);

  typedef enum logic [1:0] {
    ST_OK = 2'b00,
    ST_WARN = 2'b01,
    ST_FAULT = 2'b10
  } sdm_state_t;

endpackage

// [sdm_esc_if.sv]
`timescale 1ns/10ps
interface sdm_esc_if;
  logic run;
  logic expired;
  modport timer (input run, output expired);
  modport user (output run, input expired);
endinterface : sdm_esc_if

// [sdm_sync.sv]
`timescale 1ns/10ps
module sdm_sync #(
  parameter int N = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // data
  input wire logic [N-1:0] d,
  output logic [N-1:0] q
);

  logic [N-1:0] meta_r;

  // --------------------------------------------------------------
  // two flops per pin
  // --------------------------------------------------------------
  for (genvar i = 0; i < N; i++) begin : g_bit
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        meta_r[i] <= 1'b0;
        q[i] <= 1'b0;
      end else if (ce) begin
        meta_r[i] <= d[i];
        q[i] <= meta_r[i];
      end
    end
  end

endmodule // sdm_sync

// [sdm_esc_timer.sv]
`timescale 1ns/10ps
module sdm_esc_timer
  import sdm_pkg::*;
#(
  parameter logic [sdm_pkg::ESC_W-1:0] LIMIT = sdm_pkg::ESC_CYCLES_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // control
  sdm_esc_if.timer t
);

  logic [ESC_W-1:0] cnt_r;
  logic [ESC_W-1:0] cnt_nxt;
  logic hit;

  // --------------------------------------------------------------
  // counts while a warning stands, restarts when it goes
  // --------------------------------------------------------------
  assign hit = (cnt_r >= LIMIT - ESC_W'(1));
  assign cnt_nxt = !t.run ? '0 : (hit ? cnt_r : cnt_r + ESC_W'(1));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
      t.expired <= 1'b0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
      t.expired <= t.run & hit;
    end
  end

endmodule // sdm_esc_timer

// [sdm_top.sv]
`timescale 1ns/10ps
module sdm_top
  import sdm_pkg::*;
#(
  parameter logic [sdm_pkg::ESC_W-1:0] ESC_CYCLES = sdm_pkg::ESC_CYCLES_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,

  // chain side, same clock
  input wire logic [7:0] req_byte,
  input wire logic req_valid,
  input wire logic comm_err,
  output logic [7:0] resp_byte,
  output logic [7:0] warn_byte,
  output logic [7:0] err_byte,

  // device pins, asynchronous
  input wire logic safety_input_a,
  input wire logic safety_input_b,
  input wire logic actuator_seen,
  input wire logic actuator_locked,
  input wire logic door_seen,
  input wire logic fault_out_a,
  input wire logic fault_out_b,
  input wire logic cross_short,
  input wire logic temp_high,
  input wire logic actuator_bad,
  input wire logic internal_fault,
  input wire logic supply_low,

  // device controls
  output logic magnet_on,
  output logic enable_path
);

  // --------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s;

  wire in_a;
  wire in_b;
  wire act;
  wire locked;
  wire door;
  wire act_bad;
  wire intl;
  wire low_v;
  wire [DG_NWARN-1:0] warn_cause;
  wire any_warn;

  wire req_take;
  wire ack_req;
  wire door_open;
  wire ack;

  wire [7:0] cause_now;
  wire [7:0] err_set;
  wire [7:0] err_clr;
  wire [7:0] err_nxt;

  wire out_en_nxt;
  wire [7:0] resp_nxt;
  wire [7:0] warn_nxt;
  wire st_warn_nxt;
  wire st_fault_nxt;
  wire en_inputs;
  wire req7_fall;
  wire any_err_set;
  wire err_all_clear;

  logic req7_r;
  logic door_prev_r;
  logic [7:0] err_r;
  sdm_state_t state_r;
  sdm_state_t state_nxt;

  sdm_esc_if esc ();

  // --------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------
  assign pin_raw[P_IN_A] = safety_input_a;
  assign pin_raw[P_IN_B] = safety_input_b;
  assign pin_raw[P_ACT] = actuator_seen;
  assign pin_raw[P_LOCKED] = actuator_locked;
  assign pin_raw[P_DOOR] = door_seen;
  assign pin_raw[P_FLT_A] = fault_out_a;
  assign pin_raw[P_FLT_B] = fault_out_b;
  assign pin_raw[P_CROSS] = cross_short;
  assign pin_raw[P_TEMP] = temp_high;
  assign pin_raw[P_ACT_BAD] = actuator_bad;
  assign pin_raw[P_INTERNAL] = internal_fault;
  assign pin_raw[P_LOW_V] = supply_low;

  sdm_sync #(
    .N(NPIN)
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .d(pin_raw),
    .q(pin_s)
  );

  assign in_a = pin_s[P_IN_A];
  assign in_b = pin_s[P_IN_B];
  assign act = pin_s[P_ACT];
  assign locked = pin_s[P_LOCKED];
  assign door = pin_s[P_DOOR];
  assign act_bad = pin_s[P_ACT_BAD];
  assign intl = pin_s[P_INTERNAL];
  assign low_v = pin_s[P_LOW_V];

  // --------------------------------------------------------------
  // warning causes
  // --------------------------------------------------------------
  assign warn_cause[DG_OUT_A] = pin_s[P_FLT_A];
  assign warn_cause[DG_OUT_B] = pin_s[P_FLT_B];
  assign warn_cause[DG_CROSS] = pin_s[P_CROSS];
  assign warn_cause[DG_TEMP] = pin_s[P_TEMP];
  assign any_warn = |warn_cause;

  // --------------------------------------------------------------
  // escalation timer
  // --------------------------------------------------------------
  assign esc.run = any_warn;

  sdm_esc_timer #(
    .LIMIT(ESC_CYCLES)
  ) u_esc (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .t(esc.timer)
  );

  // --------------------------------------------------------------
  // request handling
  // --------------------------------------------------------------
  // requests during a link fault leave the switching state alone
  assign req_take = req_valid & ~comm_err;
  assign req7_fall = req7_r & ~req_byte[REQ_RESET];
  assign ack_req = req_take & req7_fall;
  assign door_open = door_prev_r & ~door;
  assign ack = ack_req | door_open;

  // magnet follows every accepted request
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      magnet_on <= 1'b0;
    end else if (ce && req_take) begin
      magnet_on <= req_byte[REQ_MAGNET];
    end
  end

  // bit 7 of the last accepted request, for the falling edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      req7_r <= 1'b0;
    end else if (ce && req_take) begin
      req7_r <= req_byte[REQ_RESET];
    end
  end

  // --------------------------------------------------------------
  // guard opening, a falling edge of the synced door
  // --------------------------------------------------------------
  // reset value 0 keeps a closed door at start-up from looking opened
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      door_prev_r <= 1'b0;
    end else if (ce) begin
      door_prev_r <= door;
    end
  end

  // --------------------------------------------------------------
  // error flags: set wins over acknowledge
  // --------------------------------------------------------------
  assign cause_now = {2'b00, intl, act_bad, warn_cause};
  assign err_set[DG_NWARN-1:0] = esc.expired ? warn_cause : '0;
  assign err_set[DG_ACT_BAD] = act_bad;
  assign err_set[DG_INTERNAL] = intl;
  assign err_set[DG_LOW_V:DG_COMM] = 2'b00;
  assign err_clr = ack ? ~cause_now : 8'h00;
  assign err_nxt = (err_r & ~err_clr) | err_set;
  assign any_err_set = |err_set;
  assign err_all_clear = (err_nxt == 8'h00);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      err_r <= BYTE_RST;
    end else if (ce) begin
      err_r <= err_nxt;
    end
  end

  // --------------------------------------------------------------
  // device state
  // --------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_OK: begin
        if (any_err_set) begin
          state_nxt = ST_FAULT;
        end else if (any_warn) begin
          state_nxt = ST_WARN;
        end
      end
      ST_WARN: begin
        if (any_err_set) begin
          state_nxt = ST_FAULT;
        end else if (!any_warn) begin
          state_nxt = ST_OK;
        end
      end
      ST_FAULT: begin
        if (err_all_clear) begin
          state_nxt = any_warn ? ST_WARN : ST_OK;
        end
      end
      default: begin
        state_nxt = ST_FAULT;
      end
    endcase
  end

  // --------------------------------------------------------------
  // state register
  // --------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_OK;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // --------------------------------------------------------------
  // enabling path
  // --------------------------------------------------------------
  assign st_warn_nxt = (state_nxt == ST_WARN);
  assign st_fault_nxt = (state_nxt == ST_FAULT);
  assign en_inputs = in_a & in_b & locked;
  // a fault drops the path in the same cycle as the response bit
  assign out_en_nxt = ~st_fault_nxt & en_inputs;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      enable_path <= 1'b0;
    end else if (ce) begin
      enable_path <= out_en_nxt;
    end
  end

  // --------------------------------------------------------------
  // response byte
  // --------------------------------------------------------------
  assign resp_nxt[RSP_OUT_ON] = out_en_nxt;
  assign resp_nxt[RSP_ACT] = act;
  assign resp_nxt[RSP_LOCKED] = act & locked;
  assign resp_nxt[RSP_SPARE] = 1'b0;
  assign resp_nxt[RSP_INPUTS] = in_a & in_b;
  assign resp_nxt[RSP_DOOR] = door;
  assign resp_nxt[RSP_WARN] = st_warn_nxt;
  assign resp_nxt[RSP_ERR] = st_fault_nxt;

  // --------------------------------------------------------------
  // warning diagnostic byte
  // --------------------------------------------------------------
  assign warn_nxt[DG_NWARN-1:0] = warn_cause;
  assign warn_nxt[DG_ACT_BAD] = 1'b0;
  assign warn_nxt[DG_INTERNAL] = intl;
  assign warn_nxt[DG_COMM] = comm_err;
  assign warn_nxt[DG_LOW_V] = low_v;

  // --------------------------------------------------------------
  // byte registers, all bits active high
  // --------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      resp_byte <= BYTE_RST;
    end else if (ce) begin
      resp_byte <= resp_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      warn_byte <= BYTE_RST;
    end else if (ce) begin
      warn_byte <= warn_nxt;
    end
  end

  // error byte shows the flags in the cycle they latch
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      err_byte <= BYTE_RST;
    end else if (ce) begin
      err_byte <= err_nxt;
    end
  end

endmodule // sdm_top

// [sdm_top_asserts.sv]
`timescale 1ns/10ps
module sdm_top_asserts
  import sdm_pkg::*;
#(
  parameter logic [sdm_pkg::ESC_W-1:0] ESC_CYCLES = sdm_pkg::ESC_CYCLES_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // chain side
  input wire logic [7:0] req_byte,
  input wire logic req_valid,
  input wire logic comm_err,
  input wire logic [7:0] resp_byte,
  input wire logic [7:0] warn_byte,
  input wire logic [7:0] err_byte,
  // device pins and controls
  input wire logic safety_input_a,
  input wire logic safety_input_b,
  input wire logic actuator_seen,
  input wire logic actuator_locked,
  input wire logic door_seen,
  input wire logic fault_out_a,
  input wire logic fault_out_b,
  input wire logic cross_short,
  input wire logic temp_high,
  input wire logic actuator_bad,
  input wire logic internal_fault,
  input wire logic supply_low,
  input wire logic magnet_on,
  input wire logic enable_path
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // --------------------------------------------------------------
  // enabled cycles in a row, pin history valid at 3
  // --------------------------------------------------------------
  logic [1:0] up_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) up_r <= 2'h0;
    else if (!ce) up_r <= 2'h0;
    else if (up_r != 2'h3) up_r <= up_r + 2'h1;
  end
  property p_magnet;
    ce && req_valid && !comm_err |=> magnet_on == $past(req_byte[0]);
  endproperty
  a_magnet: assert property (p_magnet) else $error("magnet follows request");
  property p_comm;
    ce |=> warn_byte[6] == $past(comm_err);
  endproperty
  a_comm: assert property (p_comm) else $error("comm warning bit");
  property p_resp3;
    !resp_byte[3];
  endproperty
  a_resp3: assert property (p_resp3) else $error("response bit 3 set");
  property p_act;
    up_r == 2'h3 |-> resp_byte[2:1] ==
      {$past(actuator_seen, 3) && $past(actuator_locked, 3), $past(actuator_seen, 3)};
  endproperty
  a_act: assert property (p_act) else $error("actuator bits");
  property p_inp;
    up_r == 2'h3 |-> resp_byte[5:4] ==
      {$past(door_seen, 3), $past(safety_input_a, 3) && $past(safety_input_b, 3)};
  endproperty
  a_inp: assert property (p_inp) else $error("input and door bits");
  property p_diag;
    up_r == 2'h3 |-> warn_byte[3:0] ==
      {$past(temp_high, 3), $past(cross_short, 3),
      $past(fault_out_b, 3), $past(fault_out_a, 3)};
  endproperty
  a_diag: assert property (p_diag) else $error("warning bits 0-3");
  property p_lowv;
    up_r == 2'h3 |-> warn_byte[7] == $past(supply_low, 3);
  endproperty
  a_lowv: assert property (p_lowv) else $error("low supply bit");
  property p_int;
    $rose(internal_fault) |-> ##3 err_byte[5] && warn_byte[5];
  endproperty
  a_int: assert property (p_int) else $error("internal fault bits");
  property p_actbad;
    $rose(actuator_bad) |-> ##3 err_byte[4];
  endproperty
  a_actbad: assert property (p_actbad) else $error("actuator fault bit");
  property p_err;
    $rose(err_byte[5]) |-> ##[0:2] resp_byte[7] && !enable_path;
  endproperty
  a_err: assert property (p_err) else $error("error not shown");
  property p_detail;
    resp_byte[7] |-> err_byte != 8'h00 || $past(err_byte) != 8'h00;
  endproperty
  a_detail: assert property (p_detail) else $error("error without detail");
endmodule // sdm_top_asserts

// [sdm_gw_model.sv]
`timescale 1ns/10ps
module sdm_gw_model (
  // clock
  input wire logic clk,
  // chain side
  output logic [7:0] req_byte,
  output logic req_valid,
  output logic comm_err
);
  initial begin
    req_byte = 8'h00;
    req_valid = 1'b0;
    comm_err = 1'b0;
  end
  // --------------------------------------------------------------
  // one request byte, valid for one edge
  // --------------------------------------------------------------
  task automatic send(input logic [7:0] b);
    @(posedge clk);
    req_byte <= b;
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    req_byte <= ~b;
  endtask
  task automatic link(input logic v);
    @(posedge clk);
    comm_err <= v;
  endtask
endmodule // sdm_gw_model

// [serial_diag_byte_map_tb.sv]
`timescale 1ns/10ps
module serial_diag_byte_map_tb;
  import sdm_pkg::*;
  localparam logic [ESC_W-1:0] ESC = 40'h00_0000_0014;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic [NPIN-1:0] pin = '0;
  logic [7:0] req_byte, resp_byte, warn_byte, err_byte;
  logic req_valid, comm_err, magnet_on, enable_path;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  int ix_a[5] = '{P_ACT, P_DOOR, P_IN_A, P_IN_B, P_LOCKED};
  logic [7:0] ex_a[5] = '{8'h02, 8'h22, 8'h22, 8'h32, 8'h37};
  int ix_w[5] = '{P_FLT_A, P_FLT_B, P_CROSS, P_TEMP, P_LOW_V};
  logic [7:0] ex_w[5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h80};
  always #10 clk = ~clk;
  sdm_gw_model gw (.clk(clk), .req_byte(req_byte), .req_valid(req_valid), .comm_err(comm_err));
  sdm_top #(.ESC_CYCLES(ESC)) dut (.clk(clk), .rstn(rstn), .ce(ce), .req_byte(req_byte),
    .req_valid(req_valid), .comm_err(comm_err), .resp_byte(resp_byte), .warn_byte(warn_byte),
    .err_byte(err_byte), .safety_input_a(pin[P_IN_A]), .safety_input_b(pin[P_IN_B]),
    .actuator_seen(pin[P_ACT]), .actuator_locked(pin[P_LOCKED]), .door_seen(pin[P_DOOR]),
    .fault_out_a(pin[P_FLT_A]), .fault_out_b(pin[P_FLT_B]), .cross_short(pin[P_CROSS]),
    .temp_high(pin[P_TEMP]), .actuator_bad(pin[P_ACT_BAD]),
    .internal_fault(pin[P_INTERNAL]), .supply_low(pin[P_LOW_V]),
    .magnet_on(magnet_on), .enable_path(enable_path));
  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic pset(input int i, input logic v);
    @(posedge clk);
    pin[i] <= v;
    repeat (4) @(negedge clk);
  endtask
  task automatic ack();
    gw.send(8'h80);
    gw.send(8'h00);
    repeat (2) @(negedge clk);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk(resp_byte | warn_byte | err_byte, 8'h00);
    for (int i = 0; i < 5; i++) begin
      pset(ix_a[i], 1'b1);
      chk(resp_byte, ex_a[i]);
    end
    chk({7'h00, enable_path}, 8'h01);
    for (int i = 0; i < 2; i++) begin
      gw.send(i ? 8'h00 : 8'h7f);
      repeat (2) @(negedge clk);
      chk({7'h00, magnet_on}, i ? 8'h00 : 8'h01);
      chk(resp_byte, 8'h37);
    end
    gw.link(1'b1);
    gw.send(8'h01);
    repeat (2) @(negedge clk);
    chk(warn_byte, 8'h40);
    chk({7'h00, magnet_on}, 8'h00);
    gw.link(1'b0);
    @(posedge clk);
    ce <= 1'b0;
    pin[P_LOW_V] <= 1'b1;
    repeat (6) @(negedge clk);
    chk(warn_byte, 8'h00);
    @(posedge clk);
    ce <= 1'b1;
    repeat (4) @(negedge clk);
    chk(warn_byte, 8'h80);
    pset(P_LOW_V, 1'b0);
    for (int i = 0; i < 5; i++) begin
      pset(ix_w[i], 1'b1);
      chk(warn_byte, ex_w[i]);
      chk({7'h00, resp_byte[RSP_WARN]}, {7'h00, i < 4});
      pset(ix_w[i], 1'b0);
    end
    pset(P_TEMP, 1'b1);
    repeat (10) @(negedge clk);
    chk(err_byte, 8'h00);
    repeat (20) @(negedge clk);
    chk(err_byte, 8'h08);
    chk({6'h00, resp_byte[RSP_ERR], enable_path}, 8'h02);
    pset(P_TEMP, 1'b0);
    chk(err_byte, 8'h08);
    ack();
    chk(err_byte, 8'h00);
    pset(P_INTERNAL, 1'b1);
    chk(err_byte, 8'h20);
    chk(warn_byte, 8'h20);
    ack();
    chk(err_byte, 8'h20);
    pset(P_INTERNAL, 1'b0);
    pset(P_DOOR, 1'b0);
    repeat (2) @(negedge clk);
    chk(err_byte, 8'h00);
    pset(P_ACT_BAD, 1'b1);
    chk(err_byte, 8'h10);
    pset(P_ACT_BAD, 1'b0);
    ack();
    chk(err_byte, 8'h00);
    close_out();
  end
endmodule // serial_diag_byte_map_tb

bind sdm_top sdm_top_asserts #(.ESC_CYCLES(ESC_CYCLES)) u_chk (.*);
